// ---- hw/baud_gen_ctrl.sv ----
`timescale 1ns/1ps
`include "baud_gen_regs.svh"
// Summary of operation
// - The internal generator counts only while the run bit is one and is held stopped while it is zero.
// - The transmitter gets the internal tick when the transmit select bit is one, else the timer overflow.
// - The receiver gets the internal tick when the receive select bit is one, else the timer overflow.
// - The speed bit selects the slow rate when zero and the fast rate when one.
// - In shift mode 0 the source bit selects oscillator divided by 12 when zero, else the internal tick.
// - Control bits 7 to 5 are reserved, read as zero here, and software must write them as zero.
// - Reset clears the five defined control bits.
// - The generator reload value comes from the reload register written by software.
module baud_gen_ctrl (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire baud_gen_pkg::sfr_req_s sfr_req_i,
   output logic [7:0] sfr_rdata_o,
   output logic sfr_hit_o,
   input wire logic timer_overflow_tick_i,
   input wire logic mode0_i,
   output baud_gen_pkg::bit_clock_s bit_clock_o,
   output logic generator_tick_o,
   output baud_gen_pkg::baud_control_s baud_control_o
);
   import baud_gen_pkg::*;

   // ==========================================
   // Helper functions
   // ==========================================
   // True when the bus address selects the given register.
   function automatic logic addr_is(
      input logic [7:0] addr,
      input logic [7:0] target
   );
      return addr == target;
   endfunction

   // Picks the internal generator tick or the alternative source for one bit clock.
   function automatic logic pick_tick(
      input logic use_internal,
      input logic internal_tick,
      input logic other_tick
   );
      return use_internal ? internal_tick : other_tick;
   endfunction

   // ==========================================
   // Register file
   // ==========================================
   baud_control_s ctrl_q;
   baud_control_s ctrl_d;
   logic [7:0] reload_q;
   logic [7:0] reload_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic hit_reload;
   logic hit_control;

   assign hit_reload = addr_is(sfr_req_i.addr, `BAUD_RELOAD_ADDR);
   assign hit_control = addr_is(sfr_req_i.addr, `BAUD_CONTROL_ADDR);

   always_comb
   begin
      ctrl_d = ctrl_q;
      reload_d = reload_q;
      rdata_d = rdata_q;
      if (sfr_req_i.wr && hit_control)
      begin
         ctrl_d = sfr_req_i.wdata[4:0];
      end
      if (sfr_req_i.wr && hit_reload)
      begin
         reload_d = sfr_req_i.wdata;
      end
      // Read data is captured once per read strobe and then held until the next read.
      if (sfr_req_i.rd)
      begin
         if (hit_control)
         begin
            rdata_d = {3'h0, ctrl_q};
         end
         else if (hit_reload)
         begin
            rdata_d = reload_q;
         end
         else
         begin
            rdata_d = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         ctrl_q <= `BAUD_CONTROL_RESET;
         reload_q <= `BAUD_RELOAD_RESET;
         rdata_q <= 8'h00;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         reload_q <= reload_d;
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata_o = rdata_q;
   assign sfr_hit_o = hit_reload | hit_control;
   assign baud_control_o = ctrl_q;

   // ==========================================
   // Internal generator
   // ==========================================
   typedef enum logic [1:0] {
      GEN_STOP = 2'b01,
      GEN_RUN = 2'b10
   } gen_state_e;

   gen_state_e state_q;
   gen_state_e state_d;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic gen_tick_q;
   logic gen_tick_d;
   logic slow_tick;
   logic step;

   // Slow rate inserts a fixed prescale before the reload counter.
   tick_divider #(
      .DIV(`SLOW_PRESCALE_DIV)
   ) u_slow_prescale (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .enable_i(ctrl_q.generator_run && !ctrl_q.speed_select),
      .tick_o(slow_tick)
   );

   assign step = ctrl_q.speed_select ? 1'b1 : slow_tick;

   always_comb
   begin
      state_d = state_q;
      count_d = count_q;
      gen_tick_d = 1'b0;
      case (state_q)
         GEN_STOP:
         begin
            // Holding the reload value while stopped makes the first period after a start a full one.
            count_d = reload_q;
            if (ctrl_q.generator_run)
            begin
               state_d = GEN_RUN;
            end
         end
         GEN_RUN:
         begin
            if (!ctrl_q.generator_run)
            begin
               state_d = GEN_STOP;
               count_d = reload_q;
            end
            else if (step)
            begin
               if (count_q == 8'hff)
               begin
                  count_d = reload_q;
                  gen_tick_d = 1'b1;
               end
               else
               begin
                  count_d = count_q + 8'h01;
               end
            end
         end
         default:
         begin
            state_d = GEN_STOP;
            count_d = reload_q;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         state_q <= GEN_STOP;
         count_q <= 8'h00;
         gen_tick_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         count_q <= count_d;
         gen_tick_q <= gen_tick_d;
      end
   end

   assign generator_tick_o = gen_tick_q;

   // ==========================================
   // Clock routing
   // ==========================================
   logic fixed_tick;

   // The fixed divider only counts in shift mode 0, so its phase restarts each time that mode is entered.
   tick_divider #(
      .DIV(`MODE0_FIXED_DIV)
   ) u_mode0_fixed (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .enable_i(mode0_i),
      .tick_o(fixed_tick)
   );

   always_comb
   begin
      // A source change takes effect in the clock after the control write, so software should switch only while the port is idle.
      bit_clock_o.tx_tick = pick_tick(ctrl_q.tx_clock_select, gen_tick_q, timer_overflow_tick_i);
      bit_clock_o.rx_tick = pick_tick(ctrl_q.rx_clock_select, gen_tick_q, timer_overflow_tick_i);
      bit_clock_o.mode0_tick = pick_tick(ctrl_q.mode0_source_select, gen_tick_q, fixed_tick);
   end
endmodule

// ---- hw/baud_gen_pkg.sv ----
package baud_gen_pkg;
   typedef struct packed {
      logic generator_run;
      logic tx_clock_select;
      logic rx_clock_select;
      logic speed_select;
      logic mode0_source_select;
   } baud_control_s;

   typedef struct packed {
      logic tx_tick;
      logic rx_tick;
      logic mode0_tick;
   } bit_clock_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } sfr_req_s;
endpackage

// ---- hw/baud_gen_regs.svh ----
`ifndef BAUD_GEN_REGS_SVH
`define BAUD_GEN_REGS_SVH
`define BAUD_RELOAD_ADDR 8'h9a
`define BAUD_CONTROL_ADDR 8'h9b
`define BAUD_RELOAD_RESET 8'h00
`define BAUD_CONTROL_RESET 5'h00
`define BIT_GENERATOR_RUN 4
`define BIT_TX_CLOCK_SELECT 3
`define BIT_RX_CLOCK_SELECT 2
`define BIT_SPEED_SELECT 1
`define BIT_MODE0_SOURCE_SELECT 0
`define MODE0_FIXED_DIV 4'd12
`define SLOW_PRESCALE_DIV 4'd6
`endif

// ---- hw/tick_divider.sv ----
`timescale 1ns/1ps
// Free divider producing a one-clock tick every DIV cycles while enabled.
module tick_divider #(
   parameter int unsigned DIV = 12
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic enable_i,
   output logic tick_o
);
   logic [3:0] count_q;
   logic [3:0] count_d;
   logic tick_q;
   logic tick_d;
   localparam logic [3:0] LAST = 4'(DIV - 1);

   always_comb
   begin
      count_d = count_q;
      tick_d = 1'b0;
      if (!enable_i)
      begin
         count_d = 4'h0;
      end
      else if (count_q == LAST)
      begin
         count_d = 4'h0;
         tick_d = 1'b1;
      end
      else
      begin
         count_d = count_q + 4'h1;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         count_q <= 4'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         count_q <= count_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;
endmodule

// ---- verif/baud_gen_ctrl_sva.sv ----
`timescale 1ns/1ps
module baud_gen_ctrl_sva (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire baud_gen_pkg::sfr_req_s sfr_req_i,
   input wire logic [7:0] sfr_rdata_o,
   input wire logic sfr_hit_o,
   input wire logic timer_overflow_tick_i,
   input wire logic mode0_i,
   input wire baud_gen_pkg::bit_clock_s bit_clock_o,
   input wire logic generator_tick_o,
   input wire baud_gen_pkg::baud_control_s baud_control_o
);
   import baud_gen_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ==========
   // Shadow of the reload register, kept from the bus writes.
   logic [7:0] reload_seen_q;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         reload_seen_q <= 8'h00;
      end
      else if (sfr_req_i.wr && sfr_req_i.addr == 8'h9a)
      begin
         reload_seen_q <= sfr_req_i.wdata;
      end
   end
   // ==========
   // Assertions.
   AST_TX: assert property (bit_clock_o.tx_tick == (baud_control_o.tx_clock_select ?
      generator_tick_o : timer_overflow_tick_i)) else $error("tx tick route");
   AST_RX: assert property (bit_clock_o.rx_tick == (baud_control_o.rx_clock_select ?
      generator_tick_o : timer_overflow_tick_i)) else $error("rx tick route");
   AST_M0: assert property (mode0_i && baud_control_o.mode0_source_select |->
      bit_clock_o.mode0_tick == generator_tick_o) else $error("mode0 route");
   AST_STOP: assert property (!baud_control_o.generator_run [*3] |-> !generator_tick_o)
      else $error("tick while stopped");
   AST_WR: assert property (sfr_req_i.wr && sfr_req_i.addr == 8'h9b |=>
      baud_control_o == $past(sfr_req_i.wdata[4:0])) else $error("control write");
   AST_RSV: assert property (sfr_req_i.rd && sfr_req_i.addr == 8'h9b |=>
      sfr_rdata_o[7:5] == 3'h0) else $error("reserved bits");
   AST_SLOW: assert property (!baud_control_o.speed_select && generator_tick_o |=>
      !generator_tick_o [*5]) else $error("slow rate");
   AST_ONE: assert property (generator_tick_o && $past(reload_seen_q) != 8'hff |=>
      !generator_tick_o) else $error("tick too long");
   AST_HIT: assert property (sfr_hit_o == (sfr_req_i.addr[7:1] == 7'h4d))
      else $error("hit decode");
   C_TX: cover property (baud_control_o.tx_clock_select && bit_clock_o.tx_tick);
   C_M0: cover property (mode0_i && bit_clock_o.mode0_tick);
   C_SLOW: cover property (!baud_control_o.speed_select && generator_tick_o);
endmodule

// ---- verif/serial_baud_rate_generator_control_tb_top.sv ----
`timescale 1ns/1ps
module serial_baud_rate_generator_control_tb_top;
   import baud_gen_pkg::*;
   logic clk_i = 0;
   logic reset_n_i = 0;
   logic mode0_i = 0;
   logic timer_overflow_tick_i;
   sfr_req_s sfr_req_i = '0;
   logic [7:0] sfr_rdata_o;
   logic sfr_hit_o;
   bit_clock_s bit_clock_o;
   baud_control_s baud_control_o;
   logic generator_tick_o;
   int miscompares = 0;
   int comparisons = 0;
   int k;
   baud_gen_ctrl uut (.clk_i, .reset_n_i, .sfr_req_i, .sfr_rdata_o, .sfr_hit_o,
      .timer_overflow_tick_i, .mode0_i, .bit_clock_o, .generator_tick_o, .baud_control_o);
   serial_port_model far_end (.clk_i, .reset_n_i, .timer_tick_o(timer_overflow_tick_i));
   initial forever #20 clk_i = ~clk_i;
   // ==========
   // Tasks.
   task step;
      @(posedge clk_i);
      #1;
   endtask
   task chk(input string n, input logic [7:0] e, input logic [7:0] s);
      comparisons++;
      if (s !== e)
      begin
         $display("MISMATCH %s exp %h got %h", n, e, s);
         miscompares++;
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr_req_i = '{a, d, 1'b1, 1'b0};
      step;
      sfr_req_i = '0;
      step;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      sfr_req_i = '{a, 8'h00, 1'b0, 1'b1};
      step;
      chk("rdata", e, sfr_rdata_o);
      chk("hit", {7'h00, (a == 8'h9a || a == 8'h9b)}, {7'h00, sfr_hit_o});
      sfr_req_i = '0;
      step;
   endtask
   task cnt(input int n, input int w);
      k = 0;
      repeat (n)
      begin
         step;
         k += ((w == 0 ? generator_tick_o : w == 1 ? bit_clock_o.tx_tick :
            w == 2 ? bit_clock_o.mode0_tick : bit_clock_o.rx_tick) === 1'b1);
      end
   endtask
   task period(input logic [7:0] e);
      k = 0;
      while (generator_tick_o !== 1'b1 && k < 300)
      begin
         step;
         k++;
      end
      step;
      k = 1;
      while (generator_tick_o !== 1'b1 && k < 255)
      begin
         step;
         k++;
      end
      chk("period", e, k[7:0]);
   endtask
   task report_and_stop;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========
   // Scenarios.
   task t_regs;
      rd(8'h9b, 8'h00);
      rd(8'h9a, 8'h00);
      rd(8'h9c, 8'h00);
      wr(8'h9a, 8'ha5);
      rd(8'h9a, 8'ha5);
      wr(8'h9b, 8'h1f);
      rd(8'h9b, 8'h1f);
      $display("regs done");
   endtask
   task t_rates;
      wr(8'h9a, 8'hf0);
      wr(8'h9b, 8'h1e);
      period(8'd16);
      cnt(64, 1);
      chk("internal tx", 8'd4, k[7:0]);
      cnt(64, 3);
      chk("internal rx", 8'd4, k[7:0]);
      wr(8'h9a, 8'hfe);
      wr(8'h9b, 8'h10);
      period(8'd12);
      $display("rates done");
   endtask
   task t_stop;
      wr(8'h9b, 8'h00);
      repeat (3) step;
      cnt(60, 0);
      chk("stopped", 8'd0, k[7:0]);
      cnt(70, 1);
      chk("timer tx", 8'd10, k[7:0]);
      cnt(70, 3);
      chk("timer rx", 8'd10, k[7:0]);
      mode0_i = 1;
      cnt(120, 2);
      chk("mode0 fixed", 8'd10, k[7:0]);
      wr(8'h9b, 8'h13);
      cnt(60, 2);
      chk("mode0 internal", 8'd30, k[7:0]);
      mode0_i = 0;
      $display("stop done");
   endtask
   task t_reset;
      wr(8'h9a, 8'h80);
      wr(8'h9b, 8'h1f);
      repeat (4) step;
      reset_n_i = 0;
      repeat (3) step;
      chk("control in reset", 8'h00, {3'h0, baud_control_o});
      reset_n_i = 1;
      rd(8'h9b, 8'h00);
      rd(8'h9a, 8'h00);
      cnt(40, 0);
      chk("tick after reset", 8'd0, k[7:0]);
      $display("reset done");
   endtask
   initial
   begin
      repeat (12) @(posedge clk_i);
      #1;
      reset_n_i = 1;
      t_regs;
      t_rates;
      t_stop;
      t_reset;
      report_and_stop;
   end
   initial
   begin
      repeat (2000) @(posedge clk_i);
      miscompares++;
      report_and_stop;
   end
endmodule
bind baud_gen_ctrl baud_gen_ctrl_sva sva_i (.clk_i, .reset_n_i, .sfr_req_i, .sfr_rdata_o,
   .sfr_hit_o, .timer_overflow_tick_i, .mode0_i, .bit_clock_o, .generator_tick_o, .baud_control_o);

// ---- verif/serial_port_model.sv ----
`timescale 1ns/1ps
// Timer side of the serial port: an overflow pulse every 7 cycles.
module serial_port_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   output logic timer_tick_o
);
   logic [2:0] cnt_q;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i) cnt_q <= 3'h0;
      else cnt_q <= (cnt_q == 3'h6) ? 3'h0 : cnt_q + 3'h1;
   end
   assign timer_tick_o = (cnt_q == 3'h6);
endmodule
